// *** design/pmcc_map.svh ***
// constants of the power mode and clock control block
// Functional notes
// - writing one to power_control_reg bit 0 enters Idle after that write
// - in Idle the core clock stops; interrupt, timer, watchdog, serial keep ticking
// - in Idle all core registers keep their contents
// - in Idle the address latch strobe and fetch strobe pins are driven high
// - in Idle every port pin keeps the level it had at Idle entry
// - an enabled interrupt in Idle wakes core, clears idle bit, runs service routine
// - Idle also ends on external pin reset, power-on reset or watchdog reset
// - external reset pin must stay high eight clock periods to be recognised
// - reset zeroes the program counter and power_control_reg, sets power_mode_reg to 40h; execution restarts at once
// - watchdog keeps counting in Idle; enabled time-out interrupt wakes the device
// - watchdog reset follows 512 clock periods after time-out unless restarted
// - leaving Idle by reset skips the instruction after the Idle entry
// - machine cycle is 4 clocks by default; Economy picks 4, 64 or 1024
// - in Idle the peripherals run at one quarter of the oscillator clock
// - in Economy the peripherals run at the core machine-cycle rate
// - power_mode_reg bits 7:6 select: 00 reserved, 01 four, 10 sixty-four, 11 1024
`ifndef PMCC_MAP_SVH
`define PMCC_MAP_SVH

`define PMCC_POWER_CONTROL_REG_IDLE_BIT      0
`define PMCC_POWER_CONTROL_REG_RESET         8'h00
`define PMCC_PMR_CD_HI_BIT      7
`define PMCC_PMR_CD_LO_BIT      6
`define PMCC_PMR_RESET          8'h40
`define PMCC_CD_RESERVED        2'h0
`define PMCC_CD_DIV4            2'h1
`define PMCC_CD_DIV64           2'h2
`define PMCC_CD_DIV1024         2'h3
`define PMCC_MC_LAST_DIV4       10'h003
`define PMCC_MC_LAST_DIV64      10'h03F
`define PMCC_MC_LAST_DIV1024    10'h3FF
`define PMCC_CLK_PER_PERIOD     1
`define PMCC_EXT_RST_PERIODS    8
`define PMCC_EXT_RST_CYCLES     (`PMCC_EXT_RST_PERIODS * `PMCC_CLK_PER_PERIOD)
`define PMCC_WDT_RST_PERIODS    512
`define PMCC_WDT_RST_CYCLES     (`PMCC_WDT_RST_PERIODS * `PMCC_CLK_PER_PERIOD)
`define PMCC_PORT_W             36

`endif

// *** design/pmcc_pkg.sv ***
// types of the power mode and clock control block
package pmcc_pkg;

	typedef enum logic {
		PMCC_RUN,
		PMCC_IDLE
	} pmcc_mode_t;

	typedef enum logic [1:0] {
		PMCC_DIV4,
		PMCC_DIV64,
		PMCC_DIV1024
	} pmcc_div_t;

endpackage

// *** design/pmcc_rst_if.sv ***
// carrier between the reset pin filter and the controller
`timescale 1ns/1ps
`default_nettype none

interface pmcc_rst_if;
	logic pin_level;
	logic recognised;

	modport filt (
		input  pin_level,
		output recognised
	);
	modport ctrl (
		output pin_level,
		input  recognised
	);
endinterface

`default_nettype wire

// *** design/pmcc_rst_filter.sv ***
// external reset pin qualifier
`timescale 1ns/1ps
`default_nettype none
`include "pmcc_map.svh"

module pmcc_rst_filter (
	input  wire logic  i_core_clk,
	input  wire logic  i_rst,
	pmcc_rst_if.filt   rst_bus
);

	localparam logic [3:0] HIGH_LAST = 4'(`PMCC_EXT_RST_CYCLES - 1);

	logic [3:0] high_cnt_q;
	logic       recog_q;

	// a glitch shorter than the minimum never reaches the core
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			high_cnt_q <= 4'h0;
		end else if (!rst_bus.pin_level) begin
			high_cnt_q <= 4'h0;
		end else if (high_cnt_q != HIGH_LAST) begin
			high_cnt_q <= high_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			recog_q <= 1'b0;
		end else begin
			recog_q <= rst_bus.pin_level && (high_cnt_q == HIGH_LAST);
		end
	end

	assign rst_bus.recognised = recog_q;

endmodule // pmcc_rst_filter

`default_nettype wire

// *** design/pmcc_top.sv ***
// idle and economy mode clock controller
`timescale 1ns/1ps
`default_nettype none
`include "pmcc_map.svh"

module pmcc_top (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst,
	// core writes to its power registers
	input  wire logic                    i_power_control_reg_we,
	input  wire logic [7:0]              i_power_control_reg_wdata,
	input  wire logic                    i_pmr_we,
	input  wire logic [7:0]              i_pmr_wdata,
	// wake and reset sources
	input  wire logic                    i_irq_pending,
	input  wire logic                    i_ext_rst_pin,
	input  wire logic                    i_por,
	input  wire logic                    i_wdt_timeout,
	input  wire logic                    i_wdt_irq_en,
	input  wire logic                    i_wdt_rst_en,
	input  wire logic                    i_wdt_restart,
	// core-side pin values
	input  wire logic                    i_core_ale,
	input  wire logic                    i_core_fetch_strobe,
	input  wire logic [`PMCC_PORT_W-1:0] i_core_port_out,
	// outputs
	output var  logic [7:0]              o_power_control_reg,
	output var  logic [7:0]              o_power_mode_reg,
	output var  logic                    o_idle,
	output var  logic                    o_core_tick,
	output var  logic                    o_periph_tick,
	output var  logic                    o_core_rst,
	output var  logic                    o_wake,
	output var  logic                    o_wdt_irq,
	output var  logic                    o_ale,
	output var  logic                    o_program_fetch_strobe_pin,
	output var  logic [`PMCC_PORT_W-1:0] o_port_out
);

	pmcc_rst_if rst_bus ();

	pmcc_pkg::pmcc_mode_t        mode_q;
	pmcc_pkg::pmcc_div_t         div_q;
	pmcc_pkg::pmcc_div_t         div_req;
	logic [7:0]                  power_control_reg_q;
	logic [7:0]                  pmr_q;
	logic [9:0]                  mc_cnt_q;
	logic [9:0]                  mc_last;
	logic                        mc_end;
	logic [9:0]                  wdt_cnt_q;
	logic                        wdt_arm_q;
	logic                        wdt_fire_q;
	logic                        any_rst;
	logic                        wake_req;
	logic                        idle_set;
	logic [`PMCC_PORT_W-1:0]     port_hold_q;

	localparam logic [9:0] WDT_LAST = 10'(`PMCC_WDT_RST_CYCLES - 1);

	assign rst_bus.pin_level = i_ext_rst_pin;

	pmcc_rst_filter u_rst_filter (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.rst_bus    (rst_bus)
	);

	// every reset source funnels into one core reset
	assign any_rst = i_por || rst_bus.recognised || wdt_fire_q;

	assign idle_set = i_power_control_reg_we && i_power_control_reg_wdata[`PMCC_POWER_CONTROL_REG_IDLE_BIT];
	assign wake_req = i_irq_pending || (i_wdt_timeout && i_wdt_irq_en);

	// requested divide from power_mode_reg; reserved code keeps four
	always_comb begin
		div_req = pmcc_pkg::PMCC_DIV4;
		unique case (pmr_q[`PMCC_PMR_CD_HI_BIT:`PMCC_PMR_CD_LO_BIT])
			`PMCC_CD_DIV64:   div_req = pmcc_pkg::PMCC_DIV64;
			`PMCC_CD_DIV1024: div_req = pmcc_pkg::PMCC_DIV1024;
			default:          div_req = pmcc_pkg::PMCC_DIV4;
		endcase
		// idle forces quarter-rate peripheral ticks
		if (mode_q == pmcc_pkg::PMCC_IDLE) begin
			div_req = pmcc_pkg::PMCC_DIV4;
		end
	end

	always_comb begin
		mc_last = `PMCC_MC_LAST_DIV4;
		unique case (div_q)
			pmcc_pkg::PMCC_DIV4:    mc_last = `PMCC_MC_LAST_DIV4;
			pmcc_pkg::PMCC_DIV64:   mc_last = `PMCC_MC_LAST_DIV64;
			pmcc_pkg::PMCC_DIV1024: mc_last = `PMCC_MC_LAST_DIV1024;
			default:                mc_last = `PMCC_MC_LAST_DIV4;
		endcase
	end

	assign mc_end = (mc_cnt_q == mc_last);

	// power_control_reg: idle bit set by write, cleared by wake or reset
	always_ff @(posedge i_core_clk) begin
		if (i_rst || any_rst) begin
			power_control_reg_q <= `PMCC_POWER_CONTROL_REG_RESET;
		end else if (i_power_control_reg_we) begin
			power_control_reg_q <= i_power_control_reg_wdata;
		end else if (wake_req && mode_q == pmcc_pkg::PMCC_IDLE) begin
			power_control_reg_q[`PMCC_POWER_CONTROL_REG_IDLE_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst || any_rst) begin
			pmr_q <= `PMCC_PMR_RESET;
		end else if (i_pmr_we) begin
			pmr_q <= i_pmr_wdata;
		end
	end

	// mode machine; a fresh idle write wins over a same-cycle wake
	always_ff @(posedge i_core_clk) begin
		if (i_rst || any_rst) begin
			mode_q <= pmcc_pkg::PMCC_RUN;
		end else begin
			unique case (mode_q)
				pmcc_pkg::PMCC_RUN: begin
					if (idle_set) begin
						mode_q <= pmcc_pkg::PMCC_IDLE;
					end
				end
				pmcc_pkg::PMCC_IDLE: begin
					if (idle_set) begin
						mode_q <= pmcc_pkg::PMCC_IDLE;
					end else if (wake_req) begin
						mode_q <= pmcc_pkg::PMCC_RUN;
					end
				end
			endcase
		end
	end

	// divide only swaps at a boundary so no cycle is cut short
	always_ff @(posedge i_core_clk) begin
		if (i_rst || any_rst) begin
			div_q <= pmcc_pkg::PMCC_DIV4;
		end else if (mc_end) begin
			div_q <= div_req;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst || any_rst) begin
			mc_cnt_q <= 10'h000;
		end else if (mc_end) begin
			mc_cnt_q <= 10'h000;
		end else begin
			mc_cnt_q <= mc_cnt_q + 10'h001;
		end
	end

	// core tick stops in idle so its state is frozen, peripherals go on
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_core_tick   <= 1'b0;
			o_periph_tick <= 1'b0;
		end else begin
			o_core_tick   <= mc_end && (mode_q == pmcc_pkg::PMCC_RUN)
				&& !idle_set && !any_rst;
			o_periph_tick <= mc_end && !any_rst;
		end
	end

	// watchdog reset delay after time-out; restart cancels it
	always_ff @(posedge i_core_clk) begin
		if (i_rst || i_por || rst_bus.recognised) begin
			wdt_arm_q <= 1'b0;
			wdt_cnt_q <= 10'h000;
		end else if (i_wdt_restart) begin
			wdt_arm_q <= 1'b0;
			wdt_cnt_q <= 10'h000;
		end else if (i_wdt_timeout && i_wdt_rst_en && !wdt_arm_q) begin
			wdt_arm_q <= 1'b1;
			wdt_cnt_q <= 10'h000;
		end else if (wdt_arm_q) begin
			if (wdt_cnt_q == WDT_LAST) begin
				wdt_arm_q <= 1'b0;
			end
			wdt_cnt_q <= wdt_cnt_q + 10'h001;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			wdt_fire_q <= 1'b0;
		end else begin
			wdt_fire_q <= wdt_arm_q && (wdt_cnt_q == WDT_LAST)
				&& !i_wdt_restart;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_wdt_irq <= 1'b0;
		end else begin
			o_wdt_irq <= i_wdt_timeout && i_wdt_irq_en;
		end
	end

	// reset holds the core so nothing after the idle entry executes
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_core_rst <= 1'b1;
		end else begin
			o_core_rst <= any_rst;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_wake <= 1'b0;
		end else begin
			o_wake <= (mode_q == pmcc_pkg::PMCC_IDLE) && wake_req
				&& !idle_set && !any_rst;
		end
	end

	// port levels captured on the entry write
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			port_hold_q <= '0;
		end else if (mode_q == pmcc_pkg::PMCC_RUN && idle_set) begin
			port_hold_q <= i_core_port_out;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_port_out <= '1;
		end else if (mode_q == pmcc_pkg::PMCC_IDLE) begin
			o_port_out <= port_hold_q;
		end else begin
			o_port_out <= i_core_port_out;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_ale                      <= 1'b1;
			o_program_fetch_strobe_pin <= 1'b1;
		end else if (mode_q == pmcc_pkg::PMCC_IDLE) begin
			o_ale                      <= 1'b1;
			o_program_fetch_strobe_pin <= 1'b1;
		end else begin
			o_ale                      <= i_core_ale;
			o_program_fetch_strobe_pin <= i_core_fetch_strobe;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_power_control_reg <= `PMCC_POWER_CONTROL_REG_RESET;
			o_power_mode_reg    <= `PMCC_PMR_RESET;
			o_idle              <= 1'b0;
		end else begin
			o_power_control_reg <= power_control_reg_q;
			o_power_mode_reg    <= pmr_q;
			o_idle              <= (mode_q == pmcc_pkg::PMCC_IDLE);
		end
	end

endmodule // pmcc_top

`default_nettype wire

// *** tb/pmcc_asserts.sv ***
// assertion checker for the power mode clock controller
`timescale 1ns/1ps
`default_nettype none
`include "pmcc_map.svh"

module pmcc_asserts (
	input wire logic                    i_core_clk,
	input wire logic                    i_rst,
	input wire logic                    i_power_control_reg_we,
	input wire logic [7:0]              i_power_control_reg_wdata,
	input wire logic                    i_irq_pending,
	input wire logic                    i_ext_rst_pin,
	input wire logic                    i_por,
	input wire logic [7:0]              o_power_mode_reg,
	input wire logic                    o_idle,
	input wire logic                    o_core_tick,
	input wire logic                    o_periph_tick,
	input wire logic                    o_core_rst,
	input wire logic                    o_wake,
	input wire logic                    o_ale,
	input wire logic                    o_program_fetch_strobe_pin,
	input wire logic [`PMCC_PORT_W-1:0] o_port_out
);
	logic quiet;

	// other reset sources legally reshape idle and tick timing
	assign quiet = !i_por && !i_ext_rst_pin;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence s_wake_out;
		o_wake ##1 !o_idle;
	endsequence
	sequence s_pin_held;
		i_ext_rst_pin [*8];
	endsequence
	sequence s_pin_short;
		!i_ext_rst_pin ##1 i_ext_rst_pin [*7] ##1 !i_ext_rst_pin;
	endsequence

	a_idle_entry: assert property (
		i_power_control_reg_we && i_power_control_reg_wdata[0] && quiet && !o_idle && !o_core_rst
		|-> ##2 o_idle) else $error("idle not entered");
	a_core_stopped: assert property (
		o_idle |-> !o_core_tick) else $error("core tick in idle");
	a_idle_pins: assert property (
		o_idle |-> o_ale && o_program_fetch_strobe_pin)
		else $error("strobe pins low in idle");
	a_port_hold: assert property (
		o_idle && $past(o_idle) && $past(quiet) && !o_core_rst
		|-> $stable(o_port_out)) else $error("port moved in idle");
	a_irq_wake: assert property (
		o_idle && !o_wake && !o_core_rst && i_irq_pending && quiet
		&& !i_power_control_reg_we |=> s_wake_out)
		else $error("interrupt wake missing");
	a_pin_reset: assert property (
		s_pin_held |-> ##[1:3] o_core_rst) else $error("pin reset missed");
	a_pin_short: assert property (
		s_pin_short |-> ##1 !o_core_rst [*3])
		else $error("short pin pulse reset core");
	a_por_reset: assert property (
		i_por |-> ##[1:2] o_core_rst) else $error("power-on reset missed");
	a_idle_quarter: assert property (
		o_periph_tick && o_idle ##1 (o_idle && quiet) [*4]
		|-> o_periph_tick) else $error("idle tick not quarter rate");
	a_div_sixty4: assert property (
		o_periph_tick && !o_idle && o_power_mode_reg[7:6] == 2'h2
		&& $past(o_power_mode_reg[7:6], 8) == 2'h2
		|-> ##1 !o_periph_tick [*8] ##56 o_periph_tick)
		else $error("cycle not 64 clocks");
	a_core_rate: assert property (
		o_core_tick |-> o_periph_tick) else $error("core and periph differ");
endmodule // pmcc_asserts

bind pmcc_top pmcc_asserts i_pmcc_asserts (.i_core_clk, .i_rst, .i_power_control_reg_we,
	.i_power_control_reg_wdata, .i_irq_pending, .i_ext_rst_pin, .i_por, .o_power_mode_reg,
	.o_idle, .o_core_tick, .o_periph_tick, .o_core_rst, .o_wake, .o_ale,
	.o_program_fetch_strobe_pin, .o_port_out);

`default_nettype wire

// *** tb/pmcc_core_model.sv ***
// core and peripheral stand-in facing the controller
`timescale 1ns/1ps
`default_nettype none
`include "pmcc_map.svh"

module pmcc_core_model (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_core_tick,
	input  wire logic                    i_core_rst,
	input  wire logic                    i_periph_tick,
	output var  logic [15:0]             o_pc,
	output var  logic [15:0]             o_periph_cnt,
	output var  logic                    o_ale,
	output var  logic                    o_fetch_strobe,
	output var  logic [`PMCC_PORT_W-1:0] o_port_out
);
	logic [15:0] pc_q;
	logic [15:0] pcnt_q;

	// state moves only on a core tick or a core reset, so a stopped core keeps it
	always_ff @(posedge i_core_clk) begin
		if (i_core_rst)
			pc_q <= 16'h0000;
		else if (i_core_tick)
			pc_q <= pc_q + 16'h0001;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_core_rst)
			pcnt_q <= 16'h0000;
		else if (i_periph_tick)
			pcnt_q <= pcnt_q + 16'h0001;
	end

	assign o_pc = pc_q;
	assign o_periph_cnt = pcnt_q;
	assign o_ale = pc_q[0];
	assign o_fetch_strobe = ~pc_q[0];
	// pattern changes every instruction so a frozen pin is visible
	assign o_port_out = {pc_q[3:0], pc_q, ~pc_q};
endmodule // pmcc_core_model

`default_nettype wire

// *** tb/pmcc_top_tb.sv ***
// self-checking bench for the power mode clock controller
`timescale 1ns/1ps
`default_nettype none
`include "pmcc_map.svh"

module pmcc_top_tb;
	logic                    i_core_clk = 1'b0;
	logic                    i_rst, i_power_control_reg_we, i_pmr_we, i_irq_pending;
	logic                    i_ext_rst_pin, i_por, i_wdt_timeout;
	logic                    i_wdt_irq_en, i_wdt_rst_en, i_wdt_restart;
	logic [7:0]              i_power_control_reg_wdata, i_pmr_wdata;
	logic [7:0]              o_power_control_reg, o_power_mode_reg;
	logic                    o_idle, o_core_tick, o_periph_tick, o_core_rst;
	logic                    o_wake, o_wdt_irq, o_ale;
	logic                    o_program_fetch_strobe_pin;
	logic                    i_core_ale, i_core_fetch_strobe;
	logic [`PMCC_PORT_W-1:0] i_core_port_out, o_port_out;
	logic [15:0]             pc, pcnt;
	int                      err_total = 0;
	int                      samples_checked = 0;

	pmcc_top i_pmcc_top (.i_core_clk, .i_rst, .i_power_control_reg_we, .i_power_control_reg_wdata,
		.i_pmr_we, .i_pmr_wdata, .i_irq_pending, .i_ext_rst_pin, .i_por,
		.i_wdt_timeout, .i_wdt_irq_en, .i_wdt_rst_en, .i_wdt_restart,
		.i_core_ale, .i_core_fetch_strobe, .i_core_port_out,
		.o_power_control_reg, .o_power_mode_reg, .o_idle, .o_core_tick,
		.o_periph_tick, .o_core_rst, .o_wake, .o_wdt_irq, .o_ale,
		.o_program_fetch_strobe_pin, .o_port_out);
	pmcc_core_model i_pmcc_core_model (.i_core_clk, .i_core_tick(o_core_tick),
		.i_core_rst(o_core_rst), .i_periph_tick(o_periph_tick), .o_pc(pc),
		.o_periph_cnt(pcnt), .o_ale(i_core_ale),
		.o_fetch_strobe(i_core_fetch_strobe), .o_port_out(i_core_port_out));

	always #5 i_core_clk = ~i_core_clk;

	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [35:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic sel_pmr, input logic [7:0] d);
		{i_pmr_we, i_power_control_reg_we} = {sel_pmr, !sel_pmr};
		{i_pmr_wdata, i_power_control_reg_wdata} = {d, d};
		cyc(1);
		{i_pmr_we, i_power_control_reg_we} = 2'h0;
	endtask
	task automatic rst_gone;
		for (int i = 0; i < 20 && o_core_rst !== 1'b0; i++)
			cyc(1);
	endtask
	task automatic tick_gap(output int g);
		for (int i = 0; i < 2100 && o_periph_tick !== 1'b1; i++)
			cyc(1);
		g = 1;
		cyc(1);
		while (g < 2100 && o_periph_tick !== 1'b1) begin
			cyc(1);
			g++;
		end
	endtask
	task automatic go_idle;
		logic [35:0] pv;
		pv = i_core_port_out;
		wr(1'h0, 8'h01);
		cyc(2);
		chk("idle", 1'h1, o_idle);
		chk("strobes", 2'h3, {o_ale, o_program_fetch_strobe_pin});
		chk("port", pv, o_port_out);
	endtask
	task automatic t_econ;
		logic [1:0] cd [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
		int len [4] = '{4, 64, 1024, 4};
		int g;
		for (int k = 0; k < 4; k++) begin
			wr(1'h1, {cd[k], 6'h00});
			cyc(1);
			chk("pmr", {cd[k], 6'h00}, o_power_mode_reg);
			tick_gap(g);
			tick_gap(g);
			chk("cycle length", len[k], g);
		end
	endtask
	task automatic t_idle_wake(input logic by_wdt);
		logic [15:0] p0, c0;
		go_idle();
		p0 = pc;
		c0 = pcnt;
		cyc(40);
		chk("frozen pc", p0, pc);
		chk("idle ticks", c0 + 16'h000A, pcnt);
		{i_wdt_irq_en, i_wdt_timeout, i_irq_pending} = {by_wdt, by_wdt, !by_wdt};
		cyc(1);
		// wake and watchdog interrupt are one-cycle pulses
		chk("wake", {1'h1, by_wdt}, {o_wake, o_wdt_irq});
		i_wdt_timeout = 1'b0;
		cyc(1);
		i_irq_pending = 1'b0;
		cyc(3);
		chk("idle bit", 2'h0, {o_idle, o_power_control_reg[0]});
		cyc(20);
		chk("resume", 1'h1, pc > p0 && pc < p0 + 16'h000A);
	endtask
	task automatic t_resets;
		int n;
		i_ext_rst_pin = 1'b1;
		cyc(7);
		i_ext_rst_pin = 1'b0;
		cyc(4);
		chk("short pin", 1'h0, o_core_rst);
		wr(1'h1, 8'hC0);
		cyc(1);
		go_idle();
		i_ext_rst_pin = 1'b1;
		cyc(12);
		chk("pin reset", 1'h1, o_core_rst);
		i_ext_rst_pin = 1'b0;
		rst_gone();
		chk("restart", 25'h0000080, {pc, o_power_mode_reg, o_idle});
		go_idle();
		i_por = 1'b1;
		cyc(1);
		chk("por", 1'h1, o_core_rst);
		i_por = 1'b0;
		rst_gone();
		chk("por restart", 17'h0, {pc, o_idle});
		{i_wdt_irq_en, i_wdt_rst_en, i_wdt_timeout} = 3'h3;
		cyc(1);
		i_wdt_timeout = 1'b0;
		cyc(100);
		i_wdt_restart = 1'b1;
		cyc(1);
		i_wdt_restart = 1'b0;
		// the reset pulse is short, so watch every cycle of the window
		n = 0;
		repeat (600) begin
			cyc(1);
			if (o_core_rst !== 1'b0)
				n++;
		end
		chk("restarted", 1'h0, n);
		i_wdt_timeout = 1'b1;
		cyc(1);
		i_wdt_timeout = 1'b0;
		for (n = 1; n < 600 && o_core_rst !== 1'b1; n++)
			cyc(1);
		chk("wdt delay", 1'h1, n > 512 && n < 516);
	endtask

	initial begin
		{i_power_control_reg_we, i_pmr_we, i_irq_pending, i_ext_rst_pin, i_por} = 5'h00;
		{i_wdt_timeout, i_wdt_irq_en, i_wdt_rst_en, i_wdt_restart} = 4'h0;
		{i_power_control_reg_wdata, i_pmr_wdata} = 16'h0000;
		i_rst = 1'b1;
		cyc(4);
		i_rst = 1'b0;
		cyc(1);
		chk("reset", 18'h00100, {o_power_control_reg, o_power_mode_reg, o_idle,
			o_core_rst});
		t_econ();
		t_idle_wake(1'h0);
		t_idle_wake(1'h1);
		t_resets();
		stop_test();
	end

	// whole run needs well under 10000 cycles
	initial begin
		#200000;
		err_total++;
		stop_test();
	end
endmodule // pmcc_top_tb

`default_nettype wire
